// >>> dv/pps_chk_sva.sv
// Purpose: port sampler checker
// Assumes: top ports only
// Notes:   cnt mirrors the tick
module pps_chk
	import pps_pkg::*;
#(parameter int TICK_CYCLES_P = TICK_CYCLES)
(
	input wire logic                 clock,
	input wire logic                 resetn,
	input wire pps_pkg::pps_cfg_type cfg,
	input wire pps_pkg::pps_req_type req,
	input wire pps_pkg::pps_res_type result,
	input wire logic [15:0]          port_level
);
	logic [12:0] cnt;
	always_ff @(posedge clock or negedge resetn)
		if (!resetn)
			cnt <= '0;
		else
			cnt <= cnt == 13'(TICK_CYCLES_P - 1) ? '0 : cnt + 13'h1;
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	a_res_follows: assert property (req.valid |=> result.valid) else $error("no result");
	a_res_cause: assert property (result.valid |-> $past(req.valid)) else $error("stray result");
	a_res_port: assert property (req.valid |=> result.port == $past(req.port)) else $error("port");
	a_idle_zero: assert property (!result.valid |-> result.counts == 0) else $error("idle data");
	a_level_tick: assert property ($changed(port_level) |-> $past(cnt) == 13'(TICK_CYCLES_P - 1))
		else $error("off tick");
	a_cycles_counts: assert property (result.valid |-> result.cycles <= result.counts) else $error("cycles");
	a_high_span: assert property (result.valid |-> result.high <= result.span) else $error("high");
	a_reset_quiet: assert property ($rose(resetn) |-> !result.valid) else $error("early result");
	cover property (result.valid && result.cycles == 16'h3);
	cover property (cfg.valid && cfg.param == 8'h00);
	cover property ($rose(port_level[3]));
endmodule
bind pps_sampler pps_chk #(.TICK_CYCLES_P(TICK_CYCLES_P)) pps_chk_inst (.clock(clock), .resetn(resetn),
	.cfg(cfg), .req(req), .result(result), .port_level(port_level));

// >>> dv/pps_logger.sv
// Purpose: requesting side, one strobe per ask
// Assumes: asks no closer than the bench needs
// Notes:   registered, so requests trail ask by a clock
module pps_logger
	import pps_pkg::*;
(
	input wire logic                 clock,
	input wire logic                 resetn,
	input wire logic                 ask,
	input wire logic [3:0]           ask_port,
	output     pps_pkg::pps_req_type req
);
	// asks stay far inside 15.9375 s, so counters never saturate
	always_ff @(posedge clock or negedge resetn)
		if (!resetn)
			req <= '0;
		else
			req <= '{valid: ask, port: ask_port};
endmodule

// >>> dv/testbench.sv
// Purpose: self-checking bench of the port sampler
// Assumes: tick every 8 clocks
// Notes:   edges placed on whole ticks so counts are exact
module testbench import pps_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock = 1'b0;
	logic        resetn = 1'b0;
	logic [15:0] port_in = '0;
	logic        ask = 1'b0;
	logic [3:0]  ask_port = '0;
	pps_cfg_type cfg = '0;
	pps_req_type req;
	pps_res_type result;
	pps_res_type got;
	logic [15:0] port_level;
	int          mismatches = 0;
	int          check_count = 0;
	int          c;
	// port, param, high ticks, low ticks
	int          rows[3][4] = '{'{0, 0, 2, 3}, '{5, 2, 4, 4}, '{15, 12, 14, 14}};
	pps_logger pps_logger_inst (.clock(clock), .resetn(resetn), .ask(ask), .ask_port(ask_port), .req(req));
	pps_sampler #(.TICK_CYCLES_P(8)) pps_sampler_inst (.clock(clock), .resetn(resetn), .port_in(port_in),
		.cfg(cfg), .req(req), .result(result), .port_level(port_level));
	initial forever #25 clock = ~clock;
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic ticks(input int n);
		repeat (n * 8) @(posedge clock);
	endtask
	// result stands one clock: take it mid-cycle, then hand back on an edge
	task automatic request(input int p, output pps_res_type r);
		ask <= 1'b1;
		ask_port <= 4'(p);
		@(posedge clock);
		ask <= 1'b0;
		@(posedge clock);
		@(negedge clock);
		r = result;
		@(posedge clock);
	endtask
	task automatic configure(input int p, input int n);
		cfg <= '{valid: 1'b1, port: 4'(p), param: 8'(n)};
		@(posedge clock);
		cfg <= '0;
		ticks(n + 2);
	endtask
	// bound covers the slowest filter with margin
	task automatic measure(input int p, input int lo, input int hi);
		for (c = 0; c < 200 && port_level[p] !== 1'b1; c++)
			@(negedge clock);
		check("recognise time", 16'(c >= lo && c <= hi), 16'h1);
		if (c == 200)
			complete_run();
	endtask
	initial
	begin
		repeat (8) @(posedge clock);
		check("reset level", port_level, 16'h0);
		check("reset counts", result.counts, 16'h0);
		resetn <= 1'b1;
		foreach (rows[r])
		begin
			configure(rows[r][0], rows[r][1]);
			request(rows[r][0], got);
			for (int k = 0; k < 4; k++)
			begin
				port_in[rows[r][0]] <= 1'b1;
				ticks(rows[r][2]);
				if (k == 3)
				begin
					request(rows[r][0], got);
					check("valid", 16'(got.valid), 16'h1);
					check("port", 16'(got.port), 16'(rows[r][0]));
					check("counts", got.counts, 16'h4);
					check("cycles", got.cycles, 16'h3);
					check("span", got.span, 16'(3 * (rows[r][2] + rows[r][3])));
					check("high", got.high, 16'(3 * rows[r][2]));
				end
				port_in[rows[r][0]] <= 1'b0;
				ticks(rows[r][3]);
			end
			$display("row %0d done", r);
		end
		port_in[9] <= 1'b1;
		measure(9, 97, 104);
		@(posedge clock);
		port_in[0] <= 1'b1;
		measure(0, 1, 8);
		@(posedge clock);
		configure(3, 4);
		port_in[3] <= 1'b1;
		ticks(2);
		port_in[3] <= 1'b0;
		ticks(1);
		port_in[3] <= 1'b1;
		measure(3, 25, 32);
		@(posedge clock);
		request(3, got);
		check("bounce counts", got.counts, 16'h1);
		$display("hand tests done");
		complete_run();
	end
endmodule

// >>> verilog/pps_pkg.sv
// Purpose: constants and carrier types of the port pulse sampler
// Assumes: 20 MHz module clock, 16 input ports
// Notes:   all time accumulators count 4096 Hz sample ticks
package pps_pkg;
	localparam int              NUM_PORTS      = 16;
	localparam int              PORT_IDX_W     = 4;
	localparam int              CLOCK_HZ       = 20_000_000;
	localparam int              SAMPLE_HZ      = 4096;
	// sample period in whole clocks, rounded down
	localparam int              TICK_CYCLES    = CLOCK_HZ / SAMPLE_HZ;
	localparam int              TICK_W         = 13;
	localparam int              TIME_W         = 16;
	localparam logic [15:0]     TIME_MAX       = 16'hffff;
	localparam logic [15:0]     TIME_ONE       = 16'h0001;
	localparam int              DEB_W          = 8;
	localparam int              DEB_ACC_W      = 16;
	localparam logic [15:0]     DEB_FULL       = 16'hffff;
	// n = 12 gives 13 ticks, about 3.17 ms
	localparam logic [7:0]      DEB_DEFAULT_N  = 8'h0c;
	localparam logic [15:0]     DEB_DEFAULT_STEP  = 16'(DEB_FULL / ({8'h00, DEB_DEFAULT_N} + 16'h0001));
	localparam logic [15:0]     DEB_DEFAULT_LIMIT = 16'(DEB_DEFAULT_STEP * ({8'h00, DEB_DEFAULT_N} + 16'h0001));

	typedef struct packed {
		logic                   valid;
		logic [PORT_IDX_W-1:0]  port;
		logic [DEB_W-1:0]       param;
	} pps_cfg_type;

	typedef struct packed {
		logic                   valid;
		logic [PORT_IDX_W-1:0]  port;
	} pps_req_type;

	typedef struct packed {
		logic                   valid;
		logic [PORT_IDX_W-1:0]  port;
		logic [TIME_W-1:0]      counts;
		logic [TIME_W-1:0]      cycles;
		logic [TIME_W-1:0]      span;
		logic [TIME_W-1:0]      high;
	} pps_res_type;

	typedef struct packed {
		logic [TIME_W-1:0]      counts;
		logic [TIME_W-1:0]      cycles;
		logic [TIME_W-1:0]      span;
		logic [TIME_W-1:0]      high;
		logic [TIME_W-1:0]      run;
		logic [TIME_W-1:0]      run_high;
		logic                   started;
	} pps_chan_type;

	typedef struct packed {
		logic [DEB_W-1:0]       param;
		logic [DEB_ACC_W-1:0]   step;
		logic [DEB_ACC_W-1:0]   limit;
		logic [DEB_ACC_W-1:0]   integ;
	} pps_deb_type;

	localparam pps_deb_type     DEB_RESET = '{param: DEB_DEFAULT_N, step: DEB_DEFAULT_STEP,
	                                          limit: DEB_DEFAULT_LIMIT, integ: 16'h0000};
endpackage

// >>> verilog/pps_sampler.sv
// Purpose: sample 16 ports at 4096 Hz, debounce, count pulses, time cycles
// Assumes: port_in synchronous to clock; requests arrive at most 15.9375 s apart
// Notes:   one result per request, one clock after it
// Contract
// (RULE1) All 16 ports are sampled together on a fixed 4096 Hz tick that sets measurement resolution and range.
// (RULE2) Pulse starts and ends are found by comparing each port's current sample to its previous one; the code compares only for starts (rising edges).
// (RULE3) The source holds every high or low phase longer than one 244 us sample period.
// (RULE4) Frequency data is the count of complete cycles between requests and their span in 244 us ticks.
// (RULE5) The requester asks again within 15.9375 s so the counters cover the interval.
// (RULE6) Duty data is the high time over all complete cycles between two successive requests.
// (RULE7) A non-zero debounce parameter enables the integrator; zero uses raw samples.
// (RULE8) With filtering, each tick moves the integrator up for a high input and down for a low one.
// (RULE9) The integrator is clamped between limits and the state changes only at the opposite limit.
// (RULE10) The integrator step shrinks as the debounce parameter grows.
// (RULE11) A clean change is recognised after 0.244 ms plus n times 0.244 ms.
// (RULE12) A bounce ramps the integrator back, delaying recognition, and only one transition is counted.
// (RULE13) Out of reset every port uses a debounce time of 3.17 ms.
// (RULE14) Each request latches counts, cycles, span and high time, reports them and restarts the port.
module pps_sampler
	import pps_pkg::*;
#(
	parameter int TICK_CYCLES_P = pps_pkg::TICK_CYCLES
)
(
	input  wire logic                   clock,
	input  wire logic                   resetn,
	input  wire logic [15:0]            port_in,
	input  wire pps_pkg::pps_cfg_type   cfg,
	input  wire pps_pkg::pps_req_type   req,
	output      pps_pkg::pps_res_type   result,
	output      logic [15:0]            port_level
);
	import pps_pkg::*;

	function automatic logic [TIME_W-1:0] sat_add(input logic [TIME_W-1:0] a, input logic [TIME_W-1:0] b);
		logic [TIME_W:0] sum;
		sum = {1'b0, a} + {1'b0, b};
		return sum[TIME_W] ? TIME_MAX : sum[TIME_W-1:0];
	endfunction

	// larger n, smaller step, slower ramp
	function automatic logic [DEB_ACC_W-1:0] deb_step(input logic [DEB_W-1:0] n);
		return DEB_ACC_W'(DEB_FULL / ({8'h00, n} + 16'h0001));
	endfunction

	// limit is a whole number of steps, so a clean ramp takes exactly n+1 ticks
	function automatic logic [DEB_ACC_W-1:0] deb_limit(input logic [DEB_W-1:0] n);
		logic [31:0] prod;
		prod = 32'(deb_step(n)) * 32'({8'h00, n} + 16'h0001);
		return prod[DEB_ACC_W-1:0];
	endfunction

	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES_P - 1);

	logic [TICK_W-1:0]  tick_count;
	wire                tick = (tick_count == TICK_LAST);
	wire [TICK_W-1:0]   next_tick_count = tick ? '0 : tick_count + TICK_W'(1);

	pps_deb_type        deb [NUM_PORTS];
	pps_deb_type        next_deb [NUM_PORTS];
	pps_chan_type       chan [NUM_PORTS];
	pps_chan_type       next_chan [NUM_PORTS];
	logic [15:0]        level;
	logic [15:0]        next_level;
	pps_res_type        next_result;

	assign port_level = level;

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			tick_count <= '0;
		else
			tick_count <= next_tick_count; // [RULE1]
	end

	always_comb
	begin
		logic                   rise;
		logic [DEB_ACC_W:0]     up;
		rise = 1'b0;
		up = '0;
		next_result = '0;
		next_result.port = req.port;
		next_level = level;
		for (int i = 0; i < NUM_PORTS; i++)
		begin
			next_deb[i] = deb[i];
			next_chan[i] = chan[i];
			rise = 1'b0;
			up = {1'b0, deb[i].integ} + {1'b0, deb[i].step};
			if (tick)
			begin
				// all ports taken on the same tick
				if (deb[i].param == '0)
					next_level[i] = port_in[i]; // [RULE7] [RULE1]
				else
				begin
					if (port_in[i])
						next_deb[i].integ = (up >= {1'b0, deb[i].limit}) ? deb[i].limit
						                    : up[DEB_ACC_W-1:0]; // [RULE8] [RULE9] [RULE10]
					else
						next_deb[i].integ = (deb[i].integ > deb[i].step) ? deb[i].integ - deb[i].step
						                    : '0; // [RULE8] [RULE9] [RULE12]
					// state flips only at the far limit, so bounces give one edge
					if (next_deb[i].integ == deb[i].limit)
						next_level[i] = 1'b1; // [RULE9] [RULE11] [RULE12]
					else if (next_deb[i].integ == '0)
						next_level[i] = 1'b0; // [RULE9] [RULE11]
				end
				rise = next_level[i] & ~level[i]; // [RULE2]
				if (rise)
				begin
					next_chan[i].counts = sat_add(chan[i].counts, TIME_ONE);
					if (chan[i].started)
					begin
						// a rising edge closes one complete cycle
						next_chan[i].cycles = sat_add(chan[i].cycles, TIME_ONE); // [RULE4]
						next_chan[i].span = sat_add(chan[i].span, chan[i].run); // [RULE4]
						next_chan[i].high = sat_add(chan[i].high, chan[i].run_high); // [RULE6]
					end
					next_chan[i].run = TIME_ONE;
					next_chan[i].run_high = TIME_ONE;
					next_chan[i].started = 1'b1;
				end
				else if (chan[i].started)
				begin
					next_chan[i].run = sat_add(chan[i].run, TIME_ONE); // [RULE4]
					next_chan[i].run_high = sat_add(chan[i].run_high, TIME_W'(next_level[i])); // [RULE6]
				end
			end
			if (cfg.valid && cfg.port == PORT_IDX_W'(i))
			begin
				// restart the integrator at the limit that matches the current state
				next_deb[i].param = cfg.param; // [RULE7]
				next_deb[i].step = deb_step(cfg.param); // [RULE10]
				next_deb[i].limit = deb_limit(cfg.param); // [RULE11]
				next_deb[i].integ = next_level[i] ? deb_limit(cfg.param) : '0;
			end
			if (req.valid && req.port == PORT_IDX_W'(i))
			begin
				// an edge on the request tick both closes a cycle and opens the next
				next_result.valid = 1'b1; // [RULE14]
				next_result.counts = next_chan[i].counts;
				next_result.cycles = next_chan[i].cycles; // [RULE4]
				next_result.span = next_chan[i].span; // [RULE4]
				next_result.high = next_chan[i].high; // [RULE6]
				next_chan[i] = '0; // [RULE14]
				next_chan[i].started = rise;
				next_chan[i].run = TIME_W'(rise);
				next_chan[i].run_high = TIME_W'(rise);
			end
		end
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < NUM_PORTS; i++)
			begin
				deb[i] <= DEB_RESET; // [RULE13]
				chan[i] <= '0;
			end
			level <= '0;
			result <= '0;
		end
		else
		begin
			deb <= next_deb;
			chan <= next_chan;
			level <= next_level;
			result <= next_result;
		end
	end
endmodule
